// >>> inc/hfp_regs.svh
// Address map, field positions, reset values and attribute masks of the host FIFO port block.
// Included by the package, the top design file, the checker and the bench.
`ifndef HFP_REGS_SVH
`define HFP_REGS_SVH

`define HFP_ADDR_W 8
`define HFP_DATA_W 32
`define HFP_FIFO_DEPTH 32
`define HFP_LIM_W 6

// Aliased data windows: 16 dwords each
`define HFP_ALIAS_MASK 8'hc0
`define HFP_RXD_BASE 8'h00
`define HFP_TXD_BASE 8'h40

// Status FIFO ports and control registers
`define HFP_RXS_POP 8'h80
`define HFP_RXS_PEEK 8'h84
`define HFP_TXS_POP 8'h88
`define HFP_TXS_PEEK 8'h8c
`define HFP_ID_OFS 8'h90
`define HFP_CFG_OFS 8'h94
`define HFP_CTRL_OFS 8'h98
`define HFP_STS_OFS 8'h9c

// Size configuration fields
`define HFP_CFG_RXD_LSB 0
`define HFP_CFG_RXS_LSB 8
`define HFP_CFG_TXD_LSB 16
`define HFP_CFG_RST 32'h0020_2020
`define HFP_CFG_RW_MASK 32'h003f_3f3f
`define HFP_CFG_IMMUNE_MASK 32'h003f_0000

// Control: soft reset, self clearing
`define HFP_CTRL_SRST_BIT 0

// Status bits
`define HFP_STS_RXS_OVF 0
`define HFP_STS_TXS_OVF 1
`define HFP_STS_RXD_UNDER 2
`define HFP_STS_LINK_LATLOW 3
`define HFP_STS_ERR_LATHIGH 4
`define HFP_STS_RST 32'h0000_0008
`define HFP_STS_W1C_MASK 32'h0000_0003
`define HFP_STS_COR_MASK 32'h0000_0004
`define HFP_STS_LATLOW_MASK 32'h0000_0008
`define HFP_STS_LATHIGH_MASK 32'h0000_0010

`endif

// >>> inc/hfp_pkg.sv
// Types shared by the host FIFO port block.
// Assumes hfp_regs.svh on the include path.
`include "hfp_regs.svh"

package hfp_pkg;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [`HFP_ADDR_W-1:0] addr;
    logic [`HFP_DATA_W-1:0] wdata;
  } hfp_hostReq_t;

  typedef struct packed {
    logic valid;
    logic [`HFP_DATA_W-1:0] data;
  } hfp_word_t;

  typedef enum logic [3:0] {
    HFP_PORT_NONE,
    HFP_PORT_RXD,
    HFP_PORT_TXD,
    HFP_PORT_RXS_POP,
    HFP_PORT_RXS_PEEK,
    HFP_PORT_TXS_POP,
    HFP_PORT_TXS_PEEK,
    HFP_PORT_ID,
    HFP_PORT_CFG,
    HFP_PORT_CTRL,
    HFP_PORT_STS
  } hfp_port_t;

endpackage : hfp_pkg

// >>> verilog/hfp_fifo.sv
// Synchronous FIFO with valid/ready on both sides and a run-time fill limit.
// Assumes one clock; flush empties it in one edge.
`timescale 1ns/10ps

module hfp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  input wire logic flush,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // Size and level
  input wire logic [CNT_W-1:0] limit,
  output logic [CNT_W-1:0] count
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wrPtr_reg;
  logic [PTR_W-1:0] rdPtr_reg;
  logic [CNT_W-1:0] count_reg;
  logic push;
  logic pop;

  function automatic logic [PTR_W-1:0] incPtr(input logic [PTR_W-1:0] p);
    incPtr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : incPtr

  // Full at the configured size, never past the physical depth
  assign inReady = (count_reg < limit) && (count_reg < CNT_W'(DEPTH)) && !flush;
  assign outValid = (count_reg != '0);
  assign outData = mem[rdPtr_reg];
  assign count = count_reg;
  assign push = inValid && inReady;
  assign pop = outValid && outReady && !flush;

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= incPtr(wrPtr_reg);
      end
      if (pop) begin
        rdPtr_reg <= incPtr(rdPtr_reg);
      end
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop);
    end
  end

endmodule : hfp_fifo

// >>> verilog/hfp_attr_reg.sv
// One 32-bit register whose bits carry access attributes given as masks.
// Assumes write and read strobes are one-cycle pulses on mclk.
`timescale 1ns/10ps

module hfp_attr_reg #(
  parameter logic [31:0] RST_VAL = 32'h0000_0000,
  parameter logic [31:0] RO_MASK = 32'h0000_0000,
  parameter logic [31:0] WO_MASK = 32'h0000_0000,
  parameter logic [31:0] W1C_MASK = 32'h0000_0000,
  parameter logic [31:0] COR_MASK = 32'h0000_0000,
  parameter logic [31:0] LATLOW_MASK = 32'h0000_0000,
  parameter logic [31:0] LATHIGH_MASK = 32'h0000_0000,
  parameter logic [31:0] IMMUNE_MASK = 32'h0000_0000
) (
  // Clock and resets
  input wire logic mclk,
  input wire logic rst,
  input wire logic softRst,
  // Host access
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  input wire logic rdEn,
  output logic [31:0] rdData,
  // Hardware side
  input wire logic [31:0] hwIn,
  output logic [31:0] value
);

  localparam logic [31:0] EVT_MASK = W1C_MASK | COR_MASK;
  localparam logic [31:0] RW_MASK = ~(RO_MASK | EVT_MASK | LATLOW_MASK | LATHIGH_MASK);

  logic [31:0] val_reg;
  logic [31:0] val_next;

  always_comb begin
    val_next = val_reg;
    // Host-writable bits; read-only bits ignore writes
    if (wrEn) begin
      val_next = (val_reg & ~RW_MASK) | (wrData & RW_MASK);
    end
    val_next = (val_next & ~RO_MASK) | (hwIn & RO_MASK);
    // Event bits: clears first, then a same-cycle event sets again
    if (wrEn) begin
      val_next = val_next & ~(wrData & W1C_MASK);
    end
    if (rdEn) begin
      val_next = val_next & ~COR_MASK;
    end
    val_next = val_next | (hwIn & EVT_MASK);
    // Latched bits hold until a read, then reload the live level and latch again
    if (rdEn) begin
      val_next = (val_next & ~(LATLOW_MASK | LATHIGH_MASK)) | (hwIn & (LATLOW_MASK | LATHIGH_MASK));
    end else begin
      val_next = (val_next & ~LATLOW_MASK) | (val_reg & hwIn & LATLOW_MASK);
      val_next = (val_next & ~LATHIGH_MASK) | ((val_reg | hwIn) & LATHIGH_MASK);
    end
    if (softRst) begin
      val_next = (val_reg & IMMUNE_MASK) | (RST_VAL & ~IMMUNE_MASK);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      val_reg <= RST_VAL;
    end else begin
      val_reg <= val_next;
    end
  end

  assign rdData = val_reg & ~WO_MASK;
  assign value = val_reg;

endmodule : hfp_attr_reg

// >>> verilog/hfp_host_fifo_port.sv
// Host access logic: four FIFO ports and a small attribute-typed register set.
// Assumes the host strobes come from logic on mclk; the MAC side uses valid/ready.
`timescale 1ns/10ps
`include "hfp_regs.svh"

module hfp_host_fifo_port #(
  parameter int DEPTH = `HFP_FIFO_DEPTH,
  parameter logic [15:0] CHIP_ID = 16'h00a5 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host access port
  input wire hfp_pkg::hfp_hostReq_t hostReq,
  output logic hostReady,
  output logic [`HFP_DATA_W-1:0] hostRdData,
  output logic hostRdValid,
  // Receive data from MAC
  input wire logic rxDataValid,
  output logic rxDataReady,
  input wire logic [`HFP_DATA_W-1:0] rxDataIn,
  // Receive status from MAC
  input wire logic rxStsValid,
  output logic rxStsReady,
  input wire logic [`HFP_DATA_W-1:0] rxStsIn,
  // Transmit status from MAC
  input wire logic txStsValid,
  output logic txStsReady,
  input wire logic [`HFP_DATA_W-1:0] txStsIn,
  // Transmit data to MAC
  output hfp_pkg::hfp_word_t txDataOut,
  input wire logic txDataReady,
  // Link events
  input wire logic linkUp,
  input wire logic errEvent,
  // Soft reset seen by the rest of the device
  output logic softRstOut
);

  import hfp_pkg::*;

  localparam int CNT_W = $clog2(DEPTH + 1);

  hfp_port_t port;
  logic rdReq;
  logic wrReq;
  logic softRst_reg;
  logic [`HFP_DATA_W-1:0] rdData_next;
  logic [`HFP_DATA_W-1:0] hostRdData_reg;
  logic hostRdValid_reg;

  logic rxdValid;
  logic rxdPop;
  logic [`HFP_DATA_W-1:0] rxdHead;
  logic rxsValid;
  logic rxsPop;
  logic [`HFP_DATA_W-1:0] rxsHead;
  logic txsValid;
  logic txsPop;
  logic [`HFP_DATA_W-1:0] txsHead;
  logic txdInReady;
  logic txdPush;
  logic txdValid;
  logic [`HFP_DATA_W-1:0] txdHead;

  logic [31:0] cfgValue;
  logic [31:0] cfgRdData;
  logic [31:0] idRdData;
  logic [31:0] stsRdData;
  logic [31:0] stsHw;
  logic [CNT_W-1:0] rxdLimit;
  logic [CNT_W-1:0] rxsLimit;
  logic [CNT_W-1:0] txdLimit;

  // Dword alias window decode
  function automatic logic inWindow(input logic [`HFP_ADDR_W-1:0] a, input logic [`HFP_ADDR_W-1:0] base);
    inWindow = ((a & `HFP_ALIAS_MASK) == base) && (a[1:0] == 2'b00);
  endfunction : inWindow

  // Size field to FIFO limit
  function automatic logic [CNT_W-1:0] sizeField(input logic [31:0] cfg, input int lsb);
    logic [`HFP_LIM_W-1:0] f;
    f = cfg[lsb +: `HFP_LIM_W];
    sizeField = CNT_W'(f);
  endfunction : sizeField

  // Address decode
  always_comb begin
    port = HFP_PORT_NONE;
    if (inWindow(hostReq.addr, `HFP_RXD_BASE)) begin
      port = HFP_PORT_RXD;
    end else if (inWindow(hostReq.addr, `HFP_TXD_BASE)) begin
      port = HFP_PORT_TXD;
    end else begin
      case (hostReq.addr)
        `HFP_RXS_POP: port = HFP_PORT_RXS_POP;
        `HFP_RXS_PEEK: port = HFP_PORT_RXS_PEEK;
        `HFP_TXS_POP: port = HFP_PORT_TXS_POP;
        `HFP_TXS_PEEK: port = HFP_PORT_TXS_PEEK;
        `HFP_ID_OFS: port = HFP_PORT_ID;
        `HFP_CFG_OFS: port = HFP_PORT_CFG;
        `HFP_CTRL_OFS: port = HFP_PORT_CTRL;
        `HFP_STS_OFS: port = HFP_PORT_STS;
        default: port = HFP_PORT_NONE;
      endcase
    end
  end

  // A transmit data write stalls while that FIFO is full
  assign hostReady = !(hostReq.wr && !hostReq.rd && (port == HFP_PORT_TXD) && !txdInReady);
  assign rdReq = hostReq.rd && !hostReq.wr;
  assign wrReq = hostReq.wr && !hostReq.rd && hostReady;

  // Pops only on reads of the pop ports; writes there are ignored
  assign rxdPop = rdReq && (port == HFP_PORT_RXD) && rxdValid;
  assign rxsPop = rdReq && (port == HFP_PORT_RXS_POP) && rxsValid;
  assign txsPop = rdReq && (port == HFP_PORT_TXS_POP) && txsValid;
  assign txdPush = wrReq && (port == HFP_PORT_TXD);

  assign rxdLimit = sizeField(cfgValue, `HFP_CFG_RXD_LSB);
  assign rxsLimit = sizeField(cfgValue, `HFP_CFG_RXS_LSB);
  assign txdLimit = sizeField(cfgValue, `HFP_CFG_TXD_LSB);

  hfp_fifo #(.WIDTH(`HFP_DATA_W), .DEPTH(DEPTH)) rxDataFifo (
    .mclk(mclk),
    .rst(rst),
    .flush(softRst_reg),
    .inValid(rxDataValid),
    .inReady(rxDataReady),
    .inData(rxDataIn),
    .outValid(rxdValid),
    .outReady(rxdPop),
    .outData(rxdHead),
    .limit(rxdLimit),
    .count()
  );

  hfp_fifo #(.WIDTH(`HFP_DATA_W), .DEPTH(DEPTH)) rxStsFifo (
    .mclk(mclk),
    .rst(rst),
    .flush(softRst_reg),
    .inValid(rxStsValid),
    .inReady(rxStsReady),
    .inData(rxStsIn),
    .outValid(rxsValid),
    .outReady(rxsPop),
    .outData(rxsHead),
    .limit(rxsLimit),
    .count()
  );

  hfp_fifo #(.WIDTH(`HFP_DATA_W), .DEPTH(DEPTH)) txStsFifo (
    .mclk(mclk),
    .rst(rst),
    .flush(softRst_reg),
    .inValid(txStsValid),
    .inReady(txStsReady),
    .inData(txStsIn),
    .outValid(txsValid),
    .outReady(txsPop),
    .outData(txsHead),
    .limit(CNT_W'(DEPTH)),
    .count()
  );

  hfp_fifo #(.WIDTH(`HFP_DATA_W), .DEPTH(DEPTH)) txDataFifo (
    .mclk(mclk),
    .rst(rst),
    .flush(softRst_reg),
    .inValid(txdPush),
    .inReady(txdInReady),
    .inData(hostReq.wdata),
    .outValid(txdValid),
    .outReady(txDataReady),
    .outData(txdHead),
    .limit(txdLimit),
    .count()
  );

  assign txDataOut.valid = txdValid;
  assign txDataOut.data = txdHead;

  // Identity register, read-only
  hfp_attr_reg #(
    .RST_VAL({CHIP_ID, 16'h0000}),
    .RO_MASK(32'hffff_ffff)
  ) idReg (
    .mclk(mclk),
    .rst(rst),
    .softRst(softRst_reg),
    .wrEn(wrReq && (port == HFP_PORT_ID)),
    .wrData(hostReq.wdata),
    .rdEn(rdReq && (port == HFP_PORT_ID)),
    .rdData(idRdData),
    .hwIn({CHIP_ID, 16'h0000}),
    .value()
  );

  // Size configuration; transmit data size survives software reset
  hfp_attr_reg #(
    .RST_VAL(`HFP_CFG_RST),
    .RO_MASK(~`HFP_CFG_RW_MASK),
    .IMMUNE_MASK(`HFP_CFG_IMMUNE_MASK)
  ) cfgReg (
    .mclk(mclk),
    .rst(rst),
    .softRst(softRst_reg),
    .wrEn(wrReq && (port == HFP_PORT_CFG)),
    .wrData(hostReq.wdata),
    .rdEn(rdReq && (port == HFP_PORT_CFG)),
    .rdData(cfgRdData),
    .hwIn(32'h0000_0000),
    .value(cfgValue)
  );

  // Status events
  always_comb begin
    stsHw = 32'h0000_0000;
    stsHw[`HFP_STS_RXS_OVF] = rxStsValid && !rxStsReady;
    stsHw[`HFP_STS_TXS_OVF] = txStsValid && !txStsReady;
    stsHw[`HFP_STS_RXD_UNDER] = rdReq && (port == HFP_PORT_RXD) && !rxdValid;
    stsHw[`HFP_STS_LINK_LATLOW] = linkUp;
    stsHw[`HFP_STS_ERR_LATHIGH] = errEvent;
  end

  hfp_attr_reg #(
    .RST_VAL(`HFP_STS_RST),
    .RO_MASK(~(`HFP_STS_W1C_MASK | `HFP_STS_COR_MASK | `HFP_STS_LATLOW_MASK | `HFP_STS_LATHIGH_MASK)),
    .W1C_MASK(`HFP_STS_W1C_MASK),
    .COR_MASK(`HFP_STS_COR_MASK),
    .LATLOW_MASK(`HFP_STS_LATLOW_MASK),
    .LATHIGH_MASK(`HFP_STS_LATHIGH_MASK)
  ) stsReg (
    .mclk(mclk),
    .rst(rst),
    .softRst(softRst_reg),
    .wrEn(wrReq && (port == HFP_PORT_STS)),
    .wrData(hostReq.wdata),
    .rdEn(rdReq && (port == HFP_PORT_STS)),
    .rdData(stsRdData),
    .hwIn(stsHw),
    .value()
  );

  // Soft reset: self-clearing one-cycle pulse
  always_ff @(posedge mclk) begin
    if (rst) begin
      softRst_reg <= 1'b0;
    end else begin
      softRst_reg <= wrReq && (port == HFP_PORT_CTRL) && hostReq.wdata[`HFP_CTRL_SRST_BIT];
    end
  end

  assign softRstOut = softRst_reg;

  // Read data mux
  always_comb begin
    rdData_next = '0;
    case (port)
      HFP_PORT_RXD: rdData_next = rxdValid ? rxdHead : '0;
      HFP_PORT_RXS_POP: rdData_next = rxsValid ? rxsHead : '0;
      HFP_PORT_RXS_PEEK: rdData_next = rxsValid ? rxsHead : '0;
      HFP_PORT_TXS_POP: rdData_next = txsValid ? txsHead : '0;
      HFP_PORT_TXS_PEEK: rdData_next = txsValid ? txsHead : '0;
      HFP_PORT_TXD: rdData_next = '0;
      HFP_PORT_CTRL: rdData_next = '0;
      HFP_PORT_ID: rdData_next = idRdData;
      HFP_PORT_CFG: rdData_next = cfgRdData;
      HFP_PORT_STS: rdData_next = stsRdData;
      default: rdData_next = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hostRdData_reg <= '0;
    end else if (rdReq) begin
      hostRdData_reg <= rdData_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hostRdValid_reg <= 1'b0;
    end else begin
      hostRdValid_reg <= rdReq;
    end
  end

  assign hostRdData = hostRdData_reg;
  assign hostRdValid = hostRdValid_reg;

endmodule : hfp_host_fifo_port

// >>> dv/hfp_host_fifo_port_chk.sv
// Concurrent checks on the ports of the host FIFO port block.
// Assumes one clock mclk and synchronous active-high rst.
`timescale 1ns/10ps
`include "hfp_regs.svh"

module hfp_host_fifo_port_chk #(
  parameter logic [15:0] CHIP_ID = 16'h00a5 // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Host side
  input wire hfp_pkg::hfp_hostReq_t hostReq,
  input wire logic hostReady,
  input wire logic [`HFP_DATA_W-1:0] hostRdData,
  input wire logic hostRdValid,
  // MAC side
  input wire logic rxDataReady,
  input wire logic rxStsValid,
  input wire logic rxStsReady,
  input wire logic txStsValid,
  input wire logic txStsReady,
  input wire hfp_pkg::hfp_word_t txDataOut,
  input wire logic softRstOut
);
  import hfp_pkg::*;
  logic rdOp;
  logic wrOp;
  logic [7:0] a;
  logic txdWin;
  assign rdOp = hostReq.rd & ~hostReq.wr;
  assign wrOp = hostReq.wr & ~hostReq.rd & hostReady;
  assign a = hostReq.addr;
  assign txdWin = (a & `HFP_ALIAS_MASK) == `HFP_TXD_BASE;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_read_gets_answer: assert property (rdOp |=> hostRdValid)
    else $error("read got no answer");
  a_no_stray_answer: assert property (!rdOp |=> !hostRdValid)
    else $error("answer without read");
  a_wo_reads_zero: assert property (rdOp && (a == `HFP_CTRL_OFS || txdWin) |=> hostRdData == 32'h0)
    else $error("write-only place read nonzero");
  a_id_read_only: assert property (rdOp && a == `HFP_ID_OFS |=> hostRdData[31:16] == CHIP_ID)
    else $error("identity field changed");
  a_rxs_peek_pop: assert property (rdOp && a == `HFP_RXS_PEEK && !rxStsValid
    ##1 rdOp && a == `HFP_RXS_POP |=> hostRdData == $past(hostRdData))
    else $error("rx status pop differs from peek");
  a_txs_peek_pop: assert property (rdOp && a == `HFP_TXS_PEEK && !txStsValid
    ##1 rdOp && a == `HFP_TXS_POP |=> hostRdData == $past(hostRdData))
    else $error("tx status pop differs from peek");
  a_full_stall_only: assert property (!hostReady |-> hostReq.wr && !hostReq.rd && txdWin)
    else $error("host stalled outside tx data write");
  a_txd_push_word: assert property (wrOp && txdWin && (a[1:0] == 2'b00) && !txDataOut.valid && !softRstOut
    |=> txDataOut.valid && txDataOut.data == $past(hostReq.wdata))
    else $error("tx data write not pushed");
  a_srst_one_pulse: assert property (wrOp && a == `HFP_CTRL_OFS && hostReq.wdata[0] |=> softRstOut ##1 !softRstOut)
    else $error("soft reset pulse wrong");
  a_srst_flushes: assert property (softRstOut |-> !rxDataReady && !rxStsReady && !txStsReady)
    else $error("fifos not flushed on soft reset");
  a_rst_quiet: assert property (disable iff (1'b0) rst |=> !hostRdValid && !softRstOut && !txDataOut.valid)
    else $error("outputs active after reset");
  c_tx_full: cover property (!hostReady);
  c_soft_reset: cover property (softRstOut);
  c_peek_pop: cover property (rdOp && a == `HFP_RXS_PEEK ##1 rdOp && a == `HFP_RXS_POP);
endmodule : hfp_host_fifo_port_chk

bind hfp_host_fifo_port hfp_host_fifo_port_chk #(.CHIP_ID(CHIP_ID)) chk (.mclk(mclk), .rst(rst),
  .hostReq(hostReq), .hostReady(hostReady), .hostRdData(hostRdData), .hostRdValid(hostRdValid),
  .rxDataReady(rxDataReady), .rxStsValid(rxStsValid), .rxStsReady(rxStsReady), .txStsValid(txStsValid),
  .txStsReady(txStsReady), .txDataOut(txDataOut), .softRstOut(softRstOut));

// >>> dv/hfp_mac_model.sv
// Behavioural MAC side: three word sources and a transmit data sink.
// Assumes the bench calls push and sets stall and slow at clock edges.
`timescale 1ns/10ps

module hfp_mac_model (
  // Clock
  input wire logic mclk,
  // Sources
  output logic rxDataValid,
  input wire logic rxDataReady,
  output logic [31:0] rxDataIn,
  output logic rxStsValid,
  input wire logic rxStsReady,
  output logic [31:0] rxStsIn,
  output logic txStsValid,
  input wire logic txStsReady,
  output logic [31:0] txStsIn,
  // Sink
  input wire hfp_pkg::hfp_word_t txDataOut,
  output logic txDataReady,
  input wire logic stall,
  input wire logic slow
);
  import hfp_pkg::*;
  logic [2:0] v = 3'h0;
  logic [31:0] d [3] = '{default: 32'h0};
  logic [2:0] rdy;
  logic [31:0] got [$];
  logic pushOk;
  assign {txStsValid, rxStsValid, rxDataValid} = v;
  assign rxDataIn = d[0];
  assign rxStsIn = d[1];
  assign txStsIn = d[2];
  assign rdy = {txStsReady, rxStsReady, rxDataReady};
  initial txDataReady = 1'b0;
  // Holds a word until taken or 8 tries, then shows inverted data
  task push(input int k, input logic [31:0] x);
    pushOk = 1'b0;
    @(posedge mclk);
    v[k] <= 1'b1;
    d[k] <= x;
    for (int n = 0; n < 8 && !pushOk; n++) begin
      #1 pushOk = rdy[k] === 1'b1;
      @(posedge mclk);
    end
    v[k] <= 1'b0;
    d[k] <= ~x;
  endtask : push
  always @(posedge mclk) begin
    if (txDataOut.valid && txDataReady) begin
      got.push_back(txDataOut.data);
    end
    txDataReady <= !stall && !(slow && txDataReady);
  end
endmodule : hfp_mac_model

// >>> dv/hfp_host_fifo_port_tb_top.sv
// Self-checking bench for the host FIFO port block.
// Assumes package, design, checker and MAC model compile first.
`timescale 1ns/10ps
`include "hfp_regs.svh"

module hfp_host_fifo_port_tb_top;
  import hfp_pkg::*;
  localparam logic [15:0] CID = 16'h0123; // Arbitrary identity value
  logic mclk = 1'b0;
  logic rst = 1'b1;
  hfp_hostReq_t hostReq = '0;
  logic hostReady, hostRdValid, softRstOut, wrOk;
  logic [31:0] hostRdData, rxDataIn, rxStsIn, txStsIn;
  logic rxDataValid, rxDataReady, rxStsValid, rxStsReady, txStsValid, txStsReady, txDataReady;
  hfp_word_t txDataOut;
  logic linkUp = 1'b1;
  logic errEvent = 1'b0;
  logic stall = 1'b1;
  logic slow = 1'b0;
  int badCount = 0;
  int nCompared = 0;
  int cyc = 0;
  always #4 mclk = ~mclk;
  hfp_host_fifo_port #(.CHIP_ID(CID)) DUT (.mclk(mclk), .rst(rst), .hostReq(hostReq), .hostReady(hostReady),
    .hostRdData(hostRdData), .hostRdValid(hostRdValid), .rxDataValid(rxDataValid), .rxDataReady(rxDataReady),
    .rxDataIn(rxDataIn), .rxStsValid(rxStsValid), .rxStsReady(rxStsReady), .rxStsIn(rxStsIn),
    .txStsValid(txStsValid), .txStsReady(txStsReady), .txStsIn(txStsIn), .txDataOut(txDataOut),
    .txDataReady(txDataReady), .linkUp(linkUp), .errEvent(errEvent), .softRstOut(softRstOut));
  hfp_mac_model mac (.mclk(mclk), .rxDataValid(rxDataValid), .rxDataReady(rxDataReady), .rxDataIn(rxDataIn),
    .rxStsValid(rxStsValid), .rxStsReady(rxStsReady), .rxStsIn(rxStsIn), .txStsValid(txStsValid),
    .txStsReady(txStsReady), .txStsIn(txStsIn), .txDataOut(txDataOut), .txDataReady(txDataReady),
    .stall(stall), .slow(slow));
  task end_sim;
    $display("compared %0d, mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task rd(input logic [7:0] a);
    @(posedge mclk);
    hostReq <= '{1'b1, 1'b0, a, 32'h0};
    @(posedge mclk);
    hostReq <= '0;
    #1;
  endtask : rd
  task chk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    cmp(hostRdData, e);
  endtask : chk
  // Two reads back to back
  task rd2(input logic [7:0] a1, input logic [7:0] a2, input logic [31:0] e1, input logic [31:0] e2);
    @(posedge mclk);
    hostReq <= '{1'b1, 1'b0, a1, 32'h0};
    @(posedge mclk);
    hostReq.addr <= a2;
    #1 cmp(hostRdData, e1);
    @(posedge mclk);
    hostReq <= '0;
    #1 cmp(hostRdData, e2);
  endtask : rd2
  task wr(input logic [7:0] a, input logic [31:0] x);
    wrOk = 1'b0;
    @(posedge mclk);
    hostReq <= '{1'b0, 1'b1, a, x};
    for (int n = 0; n < 16 && !wrOk; n++) begin
      #1 wrOk = hostReady === 1'b1;
      @(posedge mclk);
    end
    hostReq <= '0;
  endtask : wr
  task t_regs;
    chk(`HFP_STS_OFS, `HFP_STS_RST);
    chk(`HFP_CFG_OFS, `HFP_CFG_RST);
    wr(`HFP_ID_OFS, 32'hffff_ffff);
    rd(`HFP_ID_OFS);
    cmp({hostRdData[31:16], 16'h0}, {CID, 16'h0});
    chk(`HFP_CTRL_OFS, 32'h0);
    $display("test regs finished");
  endtask : t_regs
  task t_srst;
    mac.push(1, 32'h5555_0001);
    wr(`HFP_CFG_OFS, 32'h0010_0505);
    wr(`HFP_CTRL_OFS, 32'h0000_0001);
    chk(`HFP_CFG_OFS, 32'h0010_2020);
    chk(`HFP_RXS_PEEK, 32'h0);
    wr(`HFP_CFG_OFS, `HFP_CFG_RST);
    $display("test soft reset finished");
  endtask : t_srst
  task t_sts;
    logic [7:0] b;
    for (int k = 1; k < 3; k++) begin
      b = (k == 1) ? `HFP_RXS_POP : `HFP_TXS_POP;
      mac.push(k, 32'ha000_0000 + k);
      mac.push(k, 32'hb000_0000 + k);
      wr(b, 32'h0);
      rd2(b + 8'h4, b, 32'ha000_0000 + k, 32'ha000_0000 + k);
      rd2(b, b + 8'h4, 32'hb000_0000 + k, 32'h0);
    end
    $display("test status ports finished");
  endtask : t_sts
  task t_rxd;
    for (int i = 0; i < 16; i++) mac.push(0, 32'h2000_0000 + i);
    wr(`HFP_RXD_BASE, 32'h0);
    for (int i = 0; i < 16; i++) chk(8'(4 * i), 32'h2000_0000 + i);
    chk(8'h3c, 32'h0);
    chk(`HFP_STS_OFS, 32'h0000_000c);
    chk(`HFP_STS_OFS, `HFP_STS_RST);
    $display("test rx data finished");
  endtask : t_rxd
  task t_w1c;
    wr(`HFP_CFG_OFS, 32'h0020_0020);
    mac.push(1, 32'h7777_0001);
    cmp({31'h0, mac.pushOk}, 32'h0);
    chk(`HFP_STS_OFS, 32'h0000_0009);
    wr(`HFP_STS_OFS, 32'h0);
    chk(`HFP_STS_OFS, 32'h0000_0009);
    wr(`HFP_STS_OFS, 32'h0000_0001);
    chk(`HFP_STS_OFS, `HFP_STS_RST);
    wr(`HFP_CFG_OFS, `HFP_CFG_RST);
    $display("test clear by one finished");
  endtask : t_w1c
  task t_latch;
    @(posedge mclk);
    linkUp <= 1'b0;
    errEvent <= 1'b1;
    @(posedge mclk);
    linkUp <= 1'b1;
    errEvent <= 1'b0;
    chk(`HFP_STS_OFS, 32'h0000_0010);
    chk(`HFP_STS_OFS, `HFP_STS_RST);
    $display("test latch finished");
  endtask : t_latch
  task t_txd;
    for (int i = 0; i < 32; i++) wr(8'h40 + 8'(4 * (i % 16)), 32'h1000_0000 + i);
    wr(8'h7c, 32'hffff_ffff);
    cmp({31'h0, wrOk}, 32'h0);
    chk(8'h44, 32'h0);
    @(posedge mclk);
    stall <= 1'b0;
    slow <= 1'b1;
    for (int n = 0; n < 200 && mac.got.size() < 32; n++) @(posedge mclk);
    for (int i = 0; i < 32; i++) cmp(mac.got[i], 32'h1000_0000 + i);
    $display("test tx data finished");
  endtask : t_txd
  initial begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_srst();
    t_sts();
    t_rxd();
    t_w1c();
    t_latch();
    t_txd();
    end_sim();
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      badCount++;
      end_sim();
    end
  end
endmodule : hfp_host_fifo_port_tb_top
